// >>> rtl/urp_clkout_gen.sv
module urp_clkout_gen
   import urp_pkg::*;
#(
   parameter int DIV = CLKOUT_DIV
) (
   input wire logic ref_clk,     // System clock
   input wire logic rst_n,       // Synchronous reset, active low
   input wire logic run,         // Divider runs while high
   output logic clk_out          // Divided clock, low while stopped
);
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic clk_q, clk_d;

   // Division from ref_clk keeps the output exactly on frequency, well inside tolerance
   always_comb begin
      cnt_d = cnt_q;
      clk_d = clk_q;
      if (!run) begin
         cnt_d = CNT_ZERO;
         clk_d = 1'b0;
      end else if (cnt_q == CNT_W'(DIV - 1)) begin
         cnt_d = CNT_ZERO;
         clk_d = ~clk_q;
      end else begin
         cnt_d = cnt_q + CNT_ONE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cnt_q <= CNT_ZERO;
         clk_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         clk_q <= clk_d;
      end
   end

   assign clk_out = clk_q;
endmodule

// >>> rtl/urp_pkg.sv
package urp_pkg;
   // ***************************************************
   // Clock and timing
   // ***************************************************
   localparam int CLK_PERIOD_NS = 100;              // ref_clk period
   localparam int MISS_TIME_NS = 800;               // Longest gap between reference edges
   // Longest time rounds down, never under one cycle
   localparam int MISS_CYC_RAW = MISS_TIME_NS / CLK_PERIOD_NS;
   localparam int MISS_CYC = (MISS_CYC_RAW < 1) ? 1 : MISS_CYC_RAW;
   localparam int LOCK_EDGES = 64;                  // Reference edges counted before lock
   localparam int CLKOUT_DIV = 2;                   // Half-period of generated clock, in ref_clk cycles
   localparam int CLKOUT_TOL_PPM = 500;             // Allowed error of generated clock
   localparam int CNT_W = 8;                        // Width of lock and miss counters
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

   // ***************************************************
   // Modes and states
   // ***************************************************
   typedef enum logic {URP_DEVICE_SOURCED, URP_LINK_SOURCED} urp_clk_mode_t;
   typedef enum logic [2:0] {ST_RESET, ST_WAIT_LOCK, ST_WAIT_STP, ST_RUN, ST_LOWPWR} urp_state_t;
endpackage

// >>> rtl/urp_startup.sv
module urp_startup
   import urp_pkg::*;
#(
   parameter int LOCK_CNT = LOCK_EDGES,
   parameter int MISS_LIM = MISS_CYC
) (
   input wire logic ref_clk,          // System clock, 10 MHz
   input wire logic rst_n,            // Synchronous reset, active low
   input wire logic ref_clock_in,     // Reference clock from outside, own domain
   input wire logic reset_n_pin,      // Device reset pin, active low, asynchronous
   input wire logic stp,              // STP from the Link, asynchronous
   input wire logic lowpwr_req,       // Enter low-power, same domain pulse
   input wire logic clkout_i,         // Clock-output pin level, strap
   output logic clkout_o,             // Clock-output pin drive value
   output logic clkout_oe_n,          // Clock-output pin enable, low drives
   output logic dir_o,                // DIR to the Link
   output logic pll_locked,           // Lock status
   output logic clk_mode,             // 1 link-sourced, 0 device-sourced
   output logic lowpwr                // Device in low-power mode
);
   // ***************************************************
   // Reference domain: edge toggle
   // ***************************************************
   logic lrst_meta_q, lrst_q, tog_q, tog_d;

   // Reset crossing into the reference domain
   always_ff @(posedge ref_clock_in) begin
      lrst_meta_q <= rst_n;
      lrst_q <= lrst_meta_q;
   end

   // Toggle once per rising edge; falling edges never clock anything
   always_comb begin
      tog_d = ~tog_q;
   end

   always_ff @(posedge ref_clock_in) begin
      if (!lrst_q) begin
         tog_q <= 1'b0;
      end else begin
         tog_q <= tog_d;
      end
   end

   // ***************************************************
   // Input synchronisers
   // ***************************************************
   logic [3:0] s1_q, s2_q;
   logic tog_s3_q;
   logic tog_s, rpin_s, stp_s, strap_s, edge_evt;

   // Every pin level passes two flops before any logic reads it
   always_ff @(posedge ref_clk) begin
      s1_q <= {tog_q, reset_n_pin, stp, clkout_i};
      s2_q <= s1_q;
      tog_s3_q <= s2_q[3];
   end

   assign tog_s = s2_q[3];
   assign rpin_s = s2_q[2];
   assign stp_s = s2_q[1];
   assign strap_s = s2_q[0];
   // Toggle crossing makes no phase assumption between the two clocks
   assign edge_evt = tog_s ^ tog_s3_q;

   // ***************************************************
   // Lock tracking
   // ***************************************************
   logic [CNT_W-1:0] edge_cnt_q, edge_cnt_d, miss_cnt_q, miss_cnt_d;
   logic locked_q, locked_d;

   // Lock after LOCK_CNT edges counted from reset release; a late clock simply counts later
   always_comb begin
      edge_cnt_d = edge_cnt_q;
      miss_cnt_d = miss_cnt_q;
      locked_d = locked_q;
      if (!rpin_s) begin
         edge_cnt_d = CNT_ZERO;
         miss_cnt_d = CNT_ZERO;
         locked_d = 1'b0;
      end else if (edge_evt) begin
         miss_cnt_d = CNT_ZERO;
         if (edge_cnt_q == CNT_W'(LOCK_CNT - 1)) begin
            locked_d = 1'b1;
         end else begin
            edge_cnt_d = edge_cnt_q + CNT_ONE;
         end
      end else if (miss_cnt_q == CNT_W'(MISS_LIM - 1)) begin
         edge_cnt_d = CNT_ZERO;
         locked_d = 1'b0;
      end else begin
         miss_cnt_d = miss_cnt_q + CNT_ONE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         edge_cnt_q <= CNT_ZERO;
         miss_cnt_q <= CNT_ZERO;
         locked_q <= 1'b0;
      end else begin
         edge_cnt_q <= edge_cnt_d;
         miss_cnt_q <= miss_cnt_d;
         locked_q <= locked_d;
      end
   end

   // ***************************************************
   // Start-up sequencer
   // ***************************************************
   urp_state_t state_q, state_d;
   urp_clk_mode_t mode_q, mode_d;
   logic dir_q, dir_d, drive_q, drive_d;

   // Strap is caught on the clock after the reset pin is seen high, never by the reset itself
   always_comb begin
      state_d = state_q;
      mode_d = mode_q;
      case (state_q)
         ST_RESET: begin
            if (rpin_s) begin
               mode_d = strap_s ? URP_LINK_SOURCED : URP_DEVICE_SOURCED;
               state_d = ST_WAIT_LOCK;
            end
         end
         ST_WAIT_LOCK: begin
            if (locked_q) begin
               state_d = ST_WAIT_STP;
            end
         end
         ST_WAIT_STP: begin
            if (!locked_q) begin
               state_d = ST_WAIT_LOCK;
            end else if (!stp_s) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!locked_q) begin
               state_d = ST_WAIT_LOCK;
            end else if (lowpwr_req) begin
               state_d = ST_LOWPWR;
            end
         end
         ST_LOWPWR: begin
            if (stp_s) begin
               state_d = ST_WAIT_LOCK;
            end
         end
         default: begin
            state_d = ST_RESET;
         end
      endcase
      if (!rpin_s) begin
         state_d = ST_RESET;
      end
   end

   // DIR high from leaving reset until lock and STP low; clock pin driven only once locked
   always_comb begin
      dir_d = (state_d == ST_WAIT_LOCK) || (state_d == ST_WAIT_STP);
      drive_d = (mode_d == URP_DEVICE_SOURCED) && locked_d &&
                (state_d == ST_WAIT_STP || state_d == ST_RUN);
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_q <= ST_RESET;
         mode_q <= URP_DEVICE_SOURCED;
         dir_q <= 1'b0;
         drive_q <= 1'b0;
      end else begin
         state_q <= state_d;
         mode_q <= mode_d;
         dir_q <= dir_d;
         drive_q <= drive_d;
      end
   end

   // ***************************************************
   // Generated clock and outputs
   // ***************************************************
   // Derived from ref_clk so frequency error is that of ref_clk alone
   urp_clkout_gen #(.DIV(CLKOUT_DIV)) u_clkgen (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .run(drive_q),
      .clk_out(clkout_o)
   );

   assign clkout_oe_n = ~drive_q;
   assign dir_o = dir_q;
   assign pll_locked = locked_q;
   assign clk_mode = mode_q;
   assign lowpwr = (state_q == ST_LOWPWR);

   // ***************************************************
   // Checks
   // ***************************************************
   strap_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_q == ST_RESET && rpin_s) |=> (mode_q == urp_clk_mode_t'($past(strap_s))))
      else $error("strap not captured into clock mode");
   // Lock may already read high for the one cycle the state takes to follow it
   dir_before_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_q == ST_WAIT_LOCK) |-> (dir_o && clkout_oe_n))
      else $error("DIR low or clock driven before lock");
   clk_after_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !clkout_oe_n |-> (pll_locked && mode_q == URP_DEVICE_SOURCED))
      else $error("clock pin driven without lock");
   link_mode_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mode_q == URP_LINK_SOURCED) |-> clkout_oe_n)
      else $error("clock pin driven in link-sourced mode");
   pin_reset_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !rpin_s |=> (state_q == ST_RESET && !pll_locked))
      else $error("start-up while reset pin low");
   lock_count_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(locked_q) |-> ($past(edge_cnt_q) == CNT_W'(LOCK_CNT - 1) && $past(edge_evt)))
      else $error("lock without full edge count");
   miss_unlock_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (miss_cnt_q == CNT_W'(MISS_LIM - 1) && !edge_evt) |=> !locked_q)
      else $error("lock kept after reference stopped");
   stp_holds_dir_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_q == ST_WAIT_STP && stp_s && rpin_s) |=> dir_o)
      else $error("DIR fell while STP high");
   dir_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_q == ST_WAIT_STP && locked_d && !stp_s && rpin_s) |=> (!dir_o [*2]))
      else $error("DIR not released after lock and STP low");
   stp_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (state_q == ST_LOWPWR && stp_s && rpin_s) |=> (state_q == ST_WAIT_LOCK && dir_o))
      else $error("no wake on STP");
endmodule

// >>> verif/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import urp_pkg::*;
   localparam int LOCK_N = 4;
   localparam int MISS_N = 8;
   logic ref_clk, rst_n, reset_n_pin, lowpwr_req, ref_run, strap_hi, stp_req;
   logic ref_clock_in, stp, clkout_i, clkout_o, clkout_oe_n, dir_o, pll_locked, clk_mode, lowpwr;
   int n_fail = 0;
   int n_tests = 0;
   int cycles = 0;
   int n;
   logic [31:0] seed = 32'h0000_1aea;
   urp_startup #(.LOCK_CNT(LOCK_N), .MISS_LIM(MISS_N)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .ref_clock_in(ref_clock_in), .reset_n_pin(reset_n_pin), .stp(stp), .lowpwr_req(lowpwr_req),
      .clkout_i(clkout_i), .clkout_o(clkout_o), .clkout_oe_n(clkout_oe_n), .dir_o(dir_o),
      .pll_locked(pll_locked), .clk_mode(clk_mode), .lowpwr(lowpwr));
   urp_link_model link (.ref_run(ref_run), .strap_hi(strap_hi), .stp_req(stp_req), .dir_o(dir_o),
      .clkout_o(clkout_o), .clkout_oe_n(clkout_oe_n), .ref_clock_in(ref_clock_in), .stp(stp),
      .clkout_i(clkout_i), .ulpi_data());
   // ***************************************************
   // Helpers
   // ***************************************************
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   // Lock bound: edges at 125 ns plus synchroniser slack
   function automatic int lock_max();
      return (LOCK_N * 125) / 100 + 8;
   endfunction
   function automatic logic sig(input int idx);
      case (idx)
         0: return pll_locked;
         1: return dir_o;
         default: return lowpwr;
      endcase
   endfunction
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Bounded wait, judged on the level reached
   task automatic wait_sig(input int idx, input logic want, input int lim);
      n = 0;
      while (sig(idx) !== want && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
      check($sformatf("wait_%0d", idx), {7'h00, sig(idx)}, {7'h00, want});
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
   endtask
   task automatic conclude();
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Hang guard, far beyond the planned run
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         conclude();
      end
   end
   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      logic last;
      int k;
      rst_n = 1'b0;
      reset_n_pin = 1'b0;
      lowpwr_req = 1'b0;
      ref_run = 1'b1;
      strap_hi = 1'b0;
      stp_req = 1'b1;
      cyc(8);
      rst_n <= 1'b1;
      // Running reference with pin low must not start
      cyc(30);
      @(negedge ref_clk);
      check("lock_pin_low", {7'h00, pll_locked}, 8'h00);
      check("dir_pin_low", {7'h00, dir_o}, 8'h00);
      // Device-sourced start with STP held a random time
      @(posedge ref_clk);
      reset_n_pin <= 1'b1;
      wait_sig(1, 1'b1, 6);
      check("mode_dev", {7'h00, clk_mode}, 8'h00);
      check("oe_before_lock", {7'h00, clkout_oe_n}, 8'h01);
      wait_sig(0, 1'b1, lock_max());
      repeat (1 + rnd() % 16) begin
         @(negedge ref_clk);
         check("dir_stp_high", {7'h00, dir_o}, 8'h01);
      end
      @(posedge ref_clk);
      stp_req <= 1'b0;
      wait_sig(1, 1'b0, 5);
      check("oe_run", {7'h00, clkout_oe_n}, 8'h00);
      // Generated clock half-period
      last = clkout_o;
      k = -99;
      repeat (4 * CLKOUT_DIV + 2) begin
         @(negedge ref_clk);
         k++;
         if (clkout_o !== last) begin
            if (k > 0)
               check("clkout_half", 8'(k), 8'(CLKOUT_DIV));
            k = 0;
            last = clkout_o;
         end
      end
      // Stopped reference drops lock, restart at random phase
      @(posedge ref_clk);
      ref_run <= 1'b0;
      wait_sig(0, 1'b0, MISS_N + 6);
      @(negedge ref_clk); // DIR follows the lock loss one cycle later
      check("dir_unlock", {7'h00, dir_o}, 8'h01);
      check("oe_unlock", {7'h00, clkout_oe_n}, 8'h01);
      #(rnd() % 125);
      ref_run = 1'b1;
      wait_sig(0, 1'b1, lock_max());
      wait_sig(1, 1'b0, 5);
      // Low power, clock stopped, STP wakes
      @(posedge ref_clk);
      lowpwr_req <= 1'b1;
      @(posedge ref_clk);
      lowpwr_req <= 1'b0;
      wait_sig(2, 1'b1, 3);
      ref_run <= 1'b0;
      cyc(20);
      @(negedge ref_clk);
      check("lowpwr_stays", {7'h00, lowpwr}, 8'h01);
      check("dir_lowpwr", {7'h00, dir_o}, 8'h00);
      @(posedge ref_clk);
      ref_run <= 1'b1;
      stp_req <= 1'b1;
      wait_sig(2, 1'b0, 5);
      check("dir_wake", {7'h00, dir_o}, 8'h01);
      cyc(3);
      stp_req <= 1'b0;
      wait_sig(0, 1'b1, lock_max());
      wait_sig(1, 1'b0, 5);
      // Link-sourced mode with a late reference
      @(posedge ref_clk);
      reset_n_pin <= 1'b0;
      ref_run <= 1'b0;
      strap_hi <= 1'b1;
      cyc(10);
      reset_n_pin <= 1'b1;
      cyc(30);
      @(negedge ref_clk);
      check("lock_no_ref", {7'h00, pll_locked}, 8'h00);
      check("dir_no_ref", {7'h00, dir_o}, 8'h01);
      check("mode_link", {7'h00, clk_mode}, 8'h01);
      @(posedge ref_clk);
      ref_run <= 1'b1;
      wait_sig(0, 1'b1, lock_max());
      check("lock_rising_only", {7'h00, n >= (LOCK_N * 125) / 100 + 1}, 8'h01);
      wait_sig(1, 1'b0, 5);
      check("oe_link", {7'h00, clkout_oe_n}, 8'h01);
      conclude();
   end
endmodule

// >>> verif/urp_link_model.sv
module urp_link_model (
   input wire logic ref_run,        // Reference clock wanted
   input wire logic strap_hi,       // Tie clock pin high
   input wire logic stp_req,        // STP wanted by the bench
   input wire logic dir_o,          // DIR from device
   input wire logic clkout_o,       // Device clock pin value
   input wire logic clkout_oe_n,    // Device clock pin enable
   output logic ref_clock_in,       // Reference clock, 125 ns
   output logic stp,                // STP to device
   output logic clkout_i,           // Resolved clock pin level
   output logic [7:0] ulpi_data     // Link data drive
);
   timeunit 1ns;
   timeprecision 100ps;
   logic auto_resume = 1'b1;
   // ***************************************************
   // Reference clock, stands low while stopped
   // ***************************************************
   initial begin
      ref_clock_in = 1'b0;
      forever #62.5 ref_clock_in = ref_run & ~ref_clock_in;
   end
   // Pin held high in link mode, otherwise pulled low until the device drives clkout_o
   assign clkout_i = clkout_oe_n ? strap_hi : clkout_o;
   assign stp = stp_req;
   // Idle bus while DIR is low, no transfers before release
   assign ulpi_data = dir_o ? 8'hzz : 8'h00;
endmodule
